// >>> pkg/fes_pkg.sv
/*
  Shared constants for the flash erase command sequencer: geometry, command words,
  status bit positions, timing counts and the host order codes.
  Assumes a single 200 MHz clock for both ends.
*/
package fes_pkg;
  // ==========================================================
  // Geometry
  localparam int AW = 12;
  localparam int DW = 16;
  localparam int SECT_LSB = 8;
  localparam int NSECT = 16;
  localparam int BANK_BIT = 11;
  localparam int TW = 16;

  // ==========================================================
  // Command sequence words
  localparam logic [AW-1:0] UNLOCK1_ADDR = 12'h555;
  localparam logic [AW-1:0] UNLOCK2_ADDR = 12'h2AA;
  localparam logic [DW-1:0] UNLOCK1_DATA = 16'h00AA;
  localparam logic [DW-1:0] UNLOCK2_DATA = 16'h0055;
  localparam logic [DW-1:0] SETUP_DATA = 16'h0080;
  localparam logic [DW-1:0] SECT_ERASE_DATA = 16'h0030;
  localparam logic [DW-1:0] CHIP_ERASE_DATA = 16'h0010;
  localparam logic [DW-1:0] SUSPEND_DATA = 16'h00B0;
  localparam logic [DW-1:0] RESUME_DATA = 16'h0030;
  localparam logic [DW-1:0] ERASED_WORD = 16'hFFFF;
  localparam logic [DW-1:0] PREPROG_WORD = 16'h0000;

  // ==========================================================
  // Status bit positions
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int WINDOW_BIT = 3;
  localparam int ETOGGLE_BIT = 2;

  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int ACCEPT_WINDOW_NS = 50000;
  localparam int ACCEPT_WINDOW_CYC = (ACCEPT_WINDOW_NS * CLK_MHZ + 999) / 1000;
  localparam int WORD_STEP_NS = 10;
  localparam int WORD_STEP_CYC = (WORD_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int HW_RESET_NS = 100;
  localparam int HW_RESET_CYC = (HW_RESET_NS * CLK_MHZ + 999) / 1000;

  // ==========================================================
  // Host orders
  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_SECT_FIRST = 3'h1,
    OP_SECT_ADD = 3'h2,
    OP_CHIP = 3'h3,
    OP_SUSPEND = 3'h4,
    OP_RESUME = 3'h5
  } fes_op_t;
endpackage

// >>> pkg/fes_if.sv
/*
  Flash bus between the host controller and the flash device end.
  Assumes both ends run on the same mclk; the wire level needs no resolution.
*/
`timescale 1ns/1ps
interface fes_if;
  logic [fes_pkg::AW-1:0] addr;
  logic [fes_pkg::DW-1:0] wdata;
  logic [fes_pkg::DW-1:0] rdata;
  logic we_n;
  logic rd;
  logic hw_reset_n;

  modport dev(input addr, input wdata, input we_n, input rd, input hw_reset_n, output rdata);
  modport host(output addr, output wdata, output we_n, output rd, output hw_reset_n,
               input rdata);
endinterface

// >>> rtl/fes_timer.sv
/*
  Loadable down counter; zero is high once the loaded count has run out.
  Assumes load and load_val come from logic on mclk.
*/
`timescale 1ns/1ps
module fes_timer #(
  parameter int W = 16
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic zero
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= load_val;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign zero = (cnt_q == '0);
endmodule

// >>> rtl/fes_flash_dev.sv
/*
  Flash device end: two-bank word array with the erase command state machine,
  acceptance window, automatic preprogram and erase walk, status reads and suspend.
  Assumes the host holds addr and wdata steady while we_n is low; a write is taken
  on the cycle in which we_n returns high.
*/
// Notes on behaviour
// R1: Erase walk zeroes targets before erasing them.
// R2: Erased sectors read back all ones.
// R3: Window stays open, adding further sector commands.
// R4: Sectors of the erasing bank join in any order, any count.
// R5: Host spaces sector commands inside window.
// R6: Other command in window returns bank read.
// R7: Window flag status bit shows window expiry.
// R8: Window timer restarts at final write edge.
// R9: Finished sector erase returns bank to read.
// R10: Non-erasing bank keeps serving array reads.
// R11: Erasing bank reads return poll/toggle status.
// R12: Running sector erase honours only suspend.
// R13: Hardware reset aborts erase; host then reissues.
// R14: Both erases share five-write unlock prefix.
// R15: Sixth write: sector code at sector address.
// R16: Chip erase sixth write: code at 555h.
// R17: Chip erase leaves whole array all ones.
// R18: Finished chip erase returns to read mode.
// R19: Chip erase ignores every command, suspend too.
// R20: Host restarts chip erase after reset.
// R21: Suspend in window ends it, suspends erase.
// R22: Bad prefix write drops back to read.
`timescale 1ns/1ps
module fes_flash_dev #(
  parameter int WIN_CYCLES = fes_pkg::ACCEPT_WINDOW_CYC,
  parameter int STEP_CYCLES = fes_pkg::WORD_STEP_CYC
) (
  input wire logic mclk,
  input wire logic srst,
  fes_if.dev bus,
  output logic busy,
  output logic suspended
);
  import fes_pkg::*;

  typedef enum logic [3:0] {
    D_READ = 4'h0,
    D_CYC2 = 4'h1,
    D_CYC3 = 4'h2,
    D_CYC4 = 4'h3,
    D_CYC5 = 4'h4,
    D_CYC6 = 4'h5,
    D_WINDOW = 4'h6,
    D_PREPROG = 4'h7,
    D_ERASE = 4'h8,
    D_SUSP = 4'h9
  } fes_dev_st_t;

  fes_dev_st_t state_q;
  fes_dev_st_t ret_q;
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic we_prev_q;
  logic [AW-1:0] wa_q;
  logic [DW-1:0] wd_q;
  logic [NSECT-1:0] set_q;
  logic chip_q;
  logic ebank_q;
  logic [AW-1:0] idx_q;
  logic tog_q;
  logic etog_q;
  logic [DW-1:0] rdata_q;
  logic take;
  logic bank_hit;
  logic abort;
  logic win_load;
  logic win_zero;
  logic step_load;
  logic step_zero;
  logic walking;
  logic tgt;
  logic mem_we;
  logic last;
  logic stat_sel;
  logic rsect_hit;
  logic [DW-1:0] status;

  // ==========================================================
  // Write capture
  always_ff @(posedge mclk) begin
    if (srst) begin
      we_prev_q <= 1'b1;
    end else begin
      we_prev_q <= bus.we_n;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      wa_q <= '0;
      wd_q <= '0;
    end else if (!bus.we_n) begin
      wa_q <= bus.addr;
      wd_q <= bus.wdata;
    end
  end

  assign take = !we_prev_q && bus.we_n; // R8
  assign bank_hit = (wa_q[BANK_BIT] == ebank_q);
  assign abort = !bus.hw_reset_n; // R13
  assign walking = (state_q == D_PREPROG) || (state_q == D_ERASE);
  assign tgt = set_q[idx_q[AW-1:SECT_LSB]];
  assign mem_we = walking && !abort && tgt && step_zero;
  assign last = (idx_q == {AW{1'b1}}) && (!tgt || step_zero);
  assign step_load = mem_we;
  assign win_load = (state_q == D_CYC6 || state_q == D_WINDOW) && take && !abort
                    && wd_q == SECT_ERASE_DATA; // R8

  // ==========================================================
  // Timers
  fes_timer #(.W(TW)) u_win (
    .mclk(mclk),
    .srst(srst),
    .load(win_load),
    .load_val(TW'(WIN_CYCLES)),
    .zero(win_zero)
  );

  fes_timer #(.W(TW)) u_step (
    .mclk(mclk),
    .srst(srst),
    .load(step_load),
    .load_val(TW'(STEP_CYCLES)),
    .zero(step_zero)
  );

  // ==========================================================
  // Command state machine
  always_ff @(posedge mclk) begin
    if (srst || abort) begin
      state_q <= D_READ; // R13
      ret_q <= D_PREPROG;
      set_q <= '0;
      chip_q <= 1'b0;
      ebank_q <= 1'b0;
      idx_q <= '0;
    end else begin
      case (state_q)
        D_READ: begin
          if (take && wa_q == UNLOCK1_ADDR && wd_q == UNLOCK1_DATA) begin
            state_q <= D_CYC2; // R14
          end
        end
        D_CYC2, D_CYC5: begin
          if (take) begin
            if (wa_q == UNLOCK2_ADDR && wd_q == UNLOCK2_DATA) begin
              state_q <= (state_q == D_CYC2) ? D_CYC3 : D_CYC6; // R14
            end else begin
              state_q <= D_READ; // R22
            end
          end
        end
        D_CYC3: begin
          if (take) begin
            state_q <= (wa_q == UNLOCK1_ADDR && wd_q == SETUP_DATA) ? D_CYC4 : D_READ; // R22
          end
        end
        D_CYC4: begin
          if (take) begin
            state_q <= (wa_q == UNLOCK1_ADDR && wd_q == UNLOCK1_DATA) ? D_CYC5 : D_READ; // R22
          end
        end
        D_CYC6: begin
          if (take) begin
            idx_q <= '0;
            if (wd_q == SECT_ERASE_DATA) begin
              state_q <= D_WINDOW; // R15
              set_q <= NSECT'(1) << wa_q[AW-1:SECT_LSB];
              ebank_q <= wa_q[BANK_BIT];
            end else if (wd_q == CHIP_ERASE_DATA && wa_q == UNLOCK1_ADDR) begin
              state_q <= D_PREPROG; // R16
              set_q <= '1;
              chip_q <= 1'b1;
            end else begin
              state_q <= D_READ; // R22
            end
          end
        end
        D_WINDOW: begin
          if (take) begin
            if (wd_q == SECT_ERASE_DATA && bank_hit) begin
              set_q <= set_q | (NSECT'(1) << wa_q[AW-1:SECT_LSB]); // R4
            end else if (wd_q == SUSPEND_DATA && bank_hit) begin
              state_q <= D_SUSP; // R21
              ret_q <= D_PREPROG;
            end else begin
              state_q <= D_READ; // R6
              set_q <= '0;
            end
          end else if (win_zero) begin
            state_q <= D_PREPROG; // R3
          end
        end
        D_PREPROG, D_ERASE: begin
          if (take && !chip_q && wd_q == SUSPEND_DATA && bank_hit) begin // R19
            state_q <= D_SUSP; // R12
            ret_q <= state_q;
          end else if (!tgt || step_zero) begin
            idx_q <= idx_q + 1'b1;
            if (last && state_q == D_PREPROG) begin
              state_q <= D_ERASE; // R1
            end else if (last) begin
              state_q <= D_READ; // R9 R18
              set_q <= '0;
              chip_q <= 1'b0;
            end
          end
        end
        D_SUSP: begin
          if (take && wd_q == RESUME_DATA && bank_hit) begin
            state_q <= ret_q; // R12
          end
        end
        default: begin
          state_q <= D_READ;
        end
      endcase
    end
  end

  // Array storage has no reset; an aborted erase leaves its words as they stood.
  always_ff @(posedge mclk) begin
    if (mem_we) begin
      mem[idx_q] <= (state_q == D_ERASE) ? ERASED_WORD : PREPROG_WORD; // R1 R2 R17
    end
  end

  // ==========================================================
  // Read path
  assign busy = (state_q == D_WINDOW) || walking;
  assign suspended = (state_q == D_SUSP);
  assign rsect_hit = set_q[bus.addr[AW-1:SECT_LSB]];
  assign stat_sel = (busy && (chip_q || bus.addr[BANK_BIT] == ebank_q))
                    || (suspended && rsect_hit); // R10 R11

  always_comb begin
    status = '0;
    status[POLL_BIT] = suspended; // R11
    status[TOGGLE_BIT] = busy && tog_q;
    status[WINDOW_BIT] = (state_q != D_WINDOW); // R7
    status[ETOGGLE_BIT] = etog_q;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      tog_q <= 1'b0;
      etog_q <= 1'b0;
    end else if (bus.rd && stat_sel) begin
      tog_q <= tog_q ^ busy; // R11
      etog_q <= etog_q ^ rsect_hit;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata_q <= '0;
    end else if (bus.rd) begin
      rdata_q <= stat_sel ? status : mem[bus.addr]; // R10 R11
    end
  end

  assign bus.rdata = rdata_q;
endmodule

// >>> rtl/fes_host_ctl.sv
/*
  Host memory controller end: turns user orders into flash write cycles, reads
  and hardware reset pulses.
  Assumes the user waits for cmd_ready and times sector additions within the window.
*/
`timescale 1ns/1ps
module fes_host_ctl #(
  parameter int RST_CYCLES = fes_pkg::HW_RESET_CYC
) (
  input wire logic mclk,
  input wire logic srst,
  fes_if.host bus,
  input wire logic cmd_valid,
  input wire fes_pkg::fes_op_t cmd_op,
  input wire logic [fes_pkg::AW-1:0] cmd_addr,
  output logic cmd_ready,
  input wire logic hw_reset_req,
  output logic rsp_valid,
  output logic [fes_pkg::DW-1:0] rsp_data
);
  import fes_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_WLO = 3'h1,
    H_WHI = 3'h2,
    H_RD = 3'h3,
    H_RCAP = 3'h4,
    H_RST = 3'h5
  } fes_host_st_t;

  fes_host_st_t state_q;
  fes_op_t op_q;
  logic [AW-1:0] uaddr_q;
  logic [2:0] step_q;
  logic [TW-1:0] rcnt_q;
  logic [AW-1:0] addr_q;
  logic [DW-1:0] wdata_q;
  logic we_n_q;
  logic rd_q;
  logic hrst_n_q;
  logic rsp_valid_q;
  logic [DW-1:0] rsp_data_q;

  // Steps 0 to 4 are the shared prefix; step 5 carries the order's own word.
  function automatic logic [AW+DW-1:0] seq_word(input logic [2:0] step, input fes_op_t op,
                                                input logic [AW-1:0] ua);
    logic [AW+DW-1:0] w;
    case (step)
      3'h0, 3'h3: w = {UNLOCK1_ADDR, UNLOCK1_DATA}; // R14
      3'h1, 3'h4: w = {UNLOCK2_ADDR, UNLOCK2_DATA};
      3'h2: w = {UNLOCK1_ADDR, SETUP_DATA};
      default: begin
        case (op)
          OP_CHIP: w = {UNLOCK1_ADDR, CHIP_ERASE_DATA}; // R16
          OP_SUSPEND: w = {ua, SUSPEND_DATA};
          OP_RESUME: w = {ua, RESUME_DATA};
          default: w = {ua, SECT_ERASE_DATA}; // R15
        endcase
      end
    endcase
    return w;
  endfunction

  assign cmd_ready = (state_q == H_IDLE);

  // ==========================================================
  // Sequencer
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= H_IDLE;
      op_q <= OP_READ;
      uaddr_q <= '0;
      step_q <= '0;
      rcnt_q <= '0;
      addr_q <= '0;
      wdata_q <= '0;
      we_n_q <= 1'b1;
      rd_q <= 1'b0;
      hrst_n_q <= 1'b1;
      rsp_valid_q <= 1'b0;
      rsp_data_q <= '0;
    end else begin
      rsp_valid_q <= 1'b0;
      if (hw_reset_req) begin
        // A cut-short sequence is dropped; the user must reissue it in full.
        state_q <= H_RST; // R13 R20
        rcnt_q <= TW'(RST_CYCLES);
        hrst_n_q <= 1'b0;
        we_n_q <= 1'b1;
        rd_q <= 1'b0;
      end else begin
        case (state_q)
          H_IDLE: begin
            if (cmd_valid && cmd_op == OP_READ) begin
              addr_q <= cmd_addr;
              rd_q <= 1'b1;
              state_q <= H_RD;
            end else if (cmd_valid) begin
              op_q <= cmd_op;
              uaddr_q <= cmd_addr;
              // A lone sector addition is one write, kept inside the window.
              step_q <= (cmd_op == OP_SECT_FIRST || cmd_op == OP_CHIP) ? 3'h0 : 3'h5; // R5
              {addr_q, wdata_q} <= seq_word((cmd_op == OP_SECT_FIRST || cmd_op == OP_CHIP)
                                            ? 3'h0 : 3'h5, cmd_op, cmd_addr);
              we_n_q <= 1'b0;
              state_q <= H_WLO;
            end
          end
          H_WLO: begin
            we_n_q <= 1'b1;
            state_q <= H_WHI;
          end
          H_WHI: begin
            if (step_q == 3'h5) begin
              state_q <= H_IDLE;
            end else begin
              step_q <= step_q + 1'b1;
              {addr_q, wdata_q} <= seq_word(step_q + 1'b1, op_q, uaddr_q); // R14
              we_n_q <= 1'b0;
              state_q <= H_WLO;
            end
          end
          H_RD: begin
            rd_q <= 1'b0;
            state_q <= H_RCAP;
          end
          H_RCAP: begin
            rsp_data_q <= bus.rdata;
            rsp_valid_q <= 1'b1;
            state_q <= H_IDLE;
          end
          H_RST: begin
            if (rcnt_q <= TW'(1)) begin
              hrst_n_q <= 1'b1;
              state_q <= H_IDLE;
            end else begin
              rcnt_q <= rcnt_q - 1'b1;
            end
          end
          default: begin
            state_q <= H_IDLE;
          end
        endcase
      end
    end
  end

  assign bus.addr = addr_q;
  assign bus.wdata = wdata_q;
  assign bus.we_n = we_n_q;
  assign bus.rd = rd_q;
  assign bus.hw_reset_n = hrst_n_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;
endmodule

// >>> dv/fes_props.sv
/*
  Checker for the erase command traffic between the host and device ends.
  Assumes it sits beside the bus interface and also sees the device status ports.
*/
`timescale 1ns/1ps
module fes_props #(
  parameter int WIN_CYCLES = 40
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [fes_pkg::AW-1:0] addr,
  input wire logic [fes_pkg::DW-1:0] wdata,
  input wire logic we_n,
  input wire logic hw_reset_n,
  input wire logic busy,
  input wire logic suspended
);
  import fes_pkg::*;
  // ==========================================================
  // Write tracking
  logic we_q, busy_q, chip_q, bank_q;
  logic [AW-1:0] a_q;
  logic [DW-1:0] d_q;
  logic [2:0] step_q;
  int win_q;
  wire take = we_n && !we_q;
  wire sixth = take && step_q == 3'h5;
  wire sect_d = d_q == SECT_ERASE_DATA;
  wire win_add = take && win_q > 0 && sect_d && a_q[BANK_BIT] == bank_q;
  function automatic logic pre_ok(input logic [2:0] s, input logic [AW-1:0] a,
                                  input logic [DW-1:0] d);
    logic u2;
    u2 = s == 3'h1 || s == 3'h4;
    return a == (u2 ? UNLOCK2_ADDR : UNLOCK1_ADDR) &&
      d == (u2 ? UNLOCK2_DATA : (s == 3'h2) ? SETUP_DATA : UNLOCK1_DATA);
  endfunction
  always_ff @(posedge mclk) begin
    we_q <= we_n;
    busy_q <= busy;
    if (!we_n) begin
      a_q <= addr;
      d_q <= wdata;
    end
  end
  always_ff @(posedge mclk) begin
    if (srst || !hw_reset_n || busy || sixth) begin
      step_q <= 3'h0;
    end else if (take) begin
      step_q <= pre_ok(step_q, a_q, d_q) ? step_q + 3'h1 : {2'h0, pre_ok(3'h0, a_q, d_q)};
    end
  end
  always_ff @(posedge mclk) begin
    if (srst || !hw_reset_n || (busy_q && !busy)) begin
      chip_q <= 1'b0;
    end else if (sixth && d_q == CHIP_ERASE_DATA) begin
      chip_q <= 1'b1;
    end
  end
  // The window count is only an estimate, so checks keep a margin of a few cycles.
  always_ff @(posedge mclk) begin
    if (sixth) begin
      bank_q <= a_q[BANK_BIT];
    end
    if (srst || !hw_reset_n || (take && win_q > 0 && !win_add)) begin
      win_q <= 0;
    end else if ((sixth && sect_d) || win_add) begin
      win_q <= WIN_CYCLES;
    end else if (win_q > 0) begin
      win_q <= win_q - 1;
    end
  end
  // ==========================================================
  // Assertions
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  chip_start_a: assert property (
    sixth && d_q == CHIP_ERASE_DATA && a_q == UNLOCK1_ADDR |-> ##[1:2] busy)
    else $error("chip erase did not start");
  sect_start_a: assert property (sixth && sect_d |-> ##[1:2] busy)
    else $error("sector erase did not start");
  chip_nosusp_a: assert property (chip_q |-> !suspended)
    else $error("chip erase was suspended");
  chip_ignore_a: assert property (chip_q && busy && take |=> busy)
    else $error("chip erase stopped by a write");
  win_abort_a: assert property (
    take && win_q > 2 && !win_add && d_q != SUSPEND_DATA |-> ##[1:2] !busy)
    else $error("window not abandoned");
  win_susp_a: assert property (
    take && win_q > 2 && d_q == SUSPEND_DATA && a_q[BANK_BIT] == bank_q |-> ##[1:4] suspended)
    else $error("suspend in window not taken");
  run_ignore_a: assert property (
    take && busy && win_q == 0 && !chip_q && d_q != SUSPEND_DATA |=> busy)
    else $error("running erase stopped by a write");
  hw_abort_a: assert property (!hw_reset_n |=> !busy && !suspended)
    else $error("hardware reset did not abort");
  susp_hold_a: assert property (
    suspended && hw_reset_n && !(take && d_q == RESUME_DATA) |=> suspended)
    else $error("suspend left without resume");
  cover property (sixth && d_q == CHIP_ERASE_DATA);
  cover property ($rose(suspended));
  cover property (!hw_reset_n && busy);
endmodule

// >>> dv/flash_erase_command_sequencer_tb_top.sv
/*
  Testbench joining the host controller and flash device ends over one bus.
  Assumes short window and walk counts set here; the array model mirrors the rules.
*/
`timescale 1ns/1ps
module flash_erase_command_sequencer_tb_top;
  import fes_pkg::*;
  localparam int WIN = 40;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic cmd_valid = 1'b0;
  fes_op_t cmd_op = OP_READ;
  logic [AW-1:0] cmd_addr = '0;
  logic hw_reset_req = 1'b0;
  logic cmd_ready, rsp_valid, busy, suspended;
  logic [DW-1:0] rsp_data, r1, r2;
  logic [DW-1:0] mdl [4096];
  logic [31:0] seed = 32'h095D;
  int fail_count = 0;
  int cmp_count = 0;
  always #2.5 mclk = ~mclk;
  fes_if bus_if();
  fes_host_ctl #(.RST_CYCLES(2)) u_fes_host_ctl (.mclk(mclk), .srst(srst), .bus(bus_if),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_ready(cmd_ready),
    .hw_reset_req(hw_reset_req), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  fes_flash_dev #(.WIN_CYCLES(WIN), .STEP_CYCLES(1)) u_fes_flash_dev (.mclk(mclk),
    .srst(srst), .bus(bus_if), .busy(busy), .suspended(suspended));
  fes_props #(.WIN_CYCLES(WIN)) u_fes_props (.mclk(mclk), .srst(srst), .addr(bus_if.addr),
    .wdata(bus_if.wdata), .we_n(bus_if.we_n), .hw_reset_n(bus_if.hw_reset_n), .busy(busy),
    .suspended(suspended));
  // ==========================================================
  // Tasks
  function automatic logic [AW-1:0] rnd(input logic [AW-1:0] base);
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return base | {4'h0, seed[7:0]};
  endfunction
  task automatic chk(input string nm, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic op(input fes_op_t o, input logic [AW-1:0] a);
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 100);
    chk("ready_wait", {15'h0, cmd_ready}, 16'h0001);
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_op <= o;
    cmd_addr <= a;
    @(posedge mclk);
    cmd_valid <= 1'b0;
  endtask
  task automatic rdw(input logic [AW-1:0] a, output logic [DW-1:0] d);
    int n;
    n = 0;
    op(OP_READ, a);
    while (rsp_valid !== 1'b1 && n < 10) begin
      @(negedge mclk);
      n++;
    end
    chk("read_wait", {15'h0, rsp_valid}, 16'h0001);
    d = rsp_data;
  endtask
  task automatic chk_arr(input logic [AW-1:0] base);
    logic [AW-1:0] a;
    logic [DW-1:0] d;
    a = rnd(base);
    rdw(a, d);
    chk("array", d, mdl[a]);
  endtask
  task automatic fill(input logic [AW-1:0] base, input int n, input logic [DW-1:0] v);
    for (int i = 0; i < n; i++) begin
      mdl[int'(base) + i] = v;
    end
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      repeat (10) @(negedge mclk);
      n++;
    end while (busy !== 1'b0 && n < 3000);
    chk("idle_wait", {15'h0, busy}, 16'h0000);
  endtask
  task automatic summarize();
    $display("Checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Sequence
  // The watchdog span covers five full array walks with room to spare.
  initial begin
    repeat (95000) @(posedge mclk);
    fail_count++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    op(OP_CHIP, UNLOCK1_ADDR);
    rdw(rnd(12'h000), r1);
    rdw(rnd(12'h800), r2);
    chk("chip_status", r1 & 16'hFFBB, 16'h0008);
    chk("chip_toggle", (r1 ^ r2) & 16'h0040, 16'h0040);
    op(OP_SUSPEND, 12'h000);
    repeat (4) @(negedge mclk);
    chk("chip_suspend", {15'h0, suspended}, 16'h0000);
    wait_idle();
    fill(12'h000, 4096, ERASED_WORD);
    for (int i = 0; i < 16; i++) begin
      chk_arr(AW'(i * 256));
    end
    op(OP_SECT_FIRST, 12'h300);
    repeat (2000) @(posedge mclk);
    hw_reset_req <= 1'b1;
    @(posedge mclk);
    hw_reset_req <= 1'b0;
    repeat (8) @(negedge mclk);
    chk("abort_busy", {15'h0, busy}, 16'h0000);
    fill(12'h300, 256, PREPROG_WORD);
    chk_arr(12'h300);
    chk_arr(12'h200);
    op(OP_SECT_FIRST, 12'h500);
    rdw(12'h000, r1);
    chk("window_status", r1 & 16'hFFBB, 16'h0000);
    op(OP_SECT_ADD, 12'h200);
    chk_arr(12'h900);
    repeat (26) @(posedge mclk);
    rdw(12'h000, r1);
    chk("window_reload", r1 & 16'h0008, 16'h0000);
    repeat (100) @(posedge mclk);
    rdw(12'h000, r1);
    chk("walk_status", r1 & 16'hFFBB, 16'h0008);
    op(OP_SECT_ADD, 12'h300);
    wait_idle();
    fill(12'h500, 256, ERASED_WORD);
    fill(12'h200, 256, ERASED_WORD);
    chk_arr(12'h500);
    chk_arr(12'h200);
    chk_arr(12'h300);
    op(OP_SECT_FIRST, 12'h400);
    op(OP_SECT_ADD, 12'hC00);
    repeat (100) @(negedge mclk);
    chk("abandon_busy", {15'h0, busy}, 16'h0000);
    op(OP_SECT_FIRST, 12'h300);
    op(OP_SUSPEND, 12'h000);
    repeat (4) @(negedge mclk);
    chk("suspended", {15'h0, suspended}, 16'h0001);
    rdw(12'h300, r1);
    chk("suspend_status", r1 & 16'hFFBB, 16'h0088);
    rdw(12'h300, r2);
    chk("erase_toggle", (r1 ^ r2) & 16'h0004, 16'h0004);
    chk_arr(12'h000);
    op(OP_RESUME, 12'h000);
    wait_idle();
    fill(12'h300, 256, ERASED_WORD);
    chk_arr(12'h300);
    chk("idle_busy", {15'h0, busy}, 16'h0000);
    summarize();
  end
endmodule
